// File: hw/vip_cfg.svh
`ifndef VIP_CFG_SVH
`define VIP_CFG_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define VIP_OFF_REQ0 8'h00
`define VIP_OFF_REQ1 8'h04
`define VIP_OFF_MASK0 8'h08
`define VIP_OFF_MASK1 8'h0C
`define VIP_OFF_PRIO0 8'h10
`define VIP_OFF_PRIO1 8'h14
`define VIP_OFF_CTRL 8'h18
`define VIP_OFF_STATUS 8'h1C

// ****************************************
// reset values and implemented flag bits
// ****************************************
`define VIP_REQ_RESET 16'h0000
`define VIP_MASK_RESET 16'hFFFF
`define VIP_PRIO_RESET 16'hFFFF
`define VIP_IMPL_0 16'hFF9F
`define VIP_IMPL_1 16'h0FBF
`define VIP_ADC_BIT 5'h10

// ****************************************
// control word fields
// ****************************************
`define VIP_CTRL_IE 0
`define VIP_CTRL_ISP 1
`define VIP_CTRL_LVMODE 2

// ****************************************
// vectors and counts
// ****************************************
`define VIP_VEC_RESET 16'h0000
`define VIP_VEC_BREAK 16'h003E
`define VIP_NUM_SRC 25
`define VIP_LAST_SRC 24

// ****************************************
// bus responses
// ****************************************
`define VIP_RESP_OKAY 2'h0
`define VIP_RESP_SLVERR 2'h2

`endif

// File: hw/vip_pkg.sv
package vip_pkg;

    typedef struct packed {
        logic serial6RxErr;
        logic serial6RxEnd;
        logic serial6TxEnd;
        logic clockedSerialEnd;
        logic serial0TxEnd;
        logic timerH1;
        logic timerH0;
        logic timer50;
        logic timer000;
        logic timer010;
        logic adcEnd;
        logic serial0Rx;
        logic rtcFixed;
        logic timer51;
        logic keyReturn;
        logic rtcInterval;
        logic timer52;
        logic timerH2;
        logic manchesterRxEnd;
        logic remoteEdge;
        logic remoteError;
        logic remoteGuidePulse;
        logic remoteDataDone;
        logic remoteShiftFull;
    } vip_periph_t;

    typedef struct packed {
        logic valid;
        logic software;
        logic [15:0] vector;
        logic savedIe;
        logic savedIsp;
    } vip_ack_t;

    typedef enum logic [1:0] {
        VIP_BUS_IDLE = 2'b01,
        VIP_BUS_RESP = 2'b10
    } vip_bus_state_t;

    typedef struct packed {
        logic [15:0] req0;
        logic [15:0] req1;
        logic [15:0] mask0;
        logic [15:0] mask1;
        logic [15:0] prio0;
        logic [15:0] prio1;
        logic globalEnable;
        logic inService;
        logic lowVoltageMode;
        logic breakPending;
        vip_ack_t ack;
        logic wakeup;
        logic resetReq;
        logic [3:0] resetCause;
        logic pinMeta;
        logic pinSync;
        vip_bus_state_t wrState;
        vip_bus_state_t rdState;
        logic awHeld;
        logic wHeld;
        logic awOut;
        logic [7:0] awAddr;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic [1:0] bresp;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } vip_state_t;

endpackage : vip_pkg

// File: hw/vip_ctrl.sv
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "vip_cfg.svh"
`default_nettype none

module vip_ctrl
#(
    parameter bit HAS_ADC = 1'b1
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic lowVoltageEvent,
    input wire logic [3:0] pinEdgeIrq,
    input wire vip_pkg::vip_periph_t periphIrq,
    input wire logic instrBoundary,
    input wire logic breakInstruction,
    input wire logic pswRestore,
    input wire logic pswRestoreIe,
    input wire logic pswRestoreIsp,
    input wire logic resetPinN,
    input wire logic powerOnClear,
    input wire logic watchdogOverflow,
    output vip_pkg::vip_ack_t ack,
    output logic standbyRelease,
    output logic resetRequest,
    output logic [3:0] resetCause,
    output logic [15:0] resetVector
);

    // ****************************************
    // source table in default order
    // ****************************************
    function automatic logic [4:0] srcPos(input int idx);
        case (idx)
            0: srcPos = 5'h00;
            1: srcPos = 5'h01;
            2: srcPos = 5'h02;
            3: srcPos = 5'h03;
            4: srcPos = 5'h04;
            5: srcPos = 5'h07;
            6: srcPos = 5'h08;
            7: srcPos = 5'h09;
            8: srcPos = 5'h0A;
            9: srcPos = 5'h0B;
            10: srcPos = 5'h0C;
            11: srcPos = 5'h0D;
            12: srcPos = 5'h0E;
            13: srcPos = 5'h0F;
            14: srcPos = 5'h10;
            15: srcPos = 5'h11;
            16: srcPos = 5'h15;
            17: srcPos = 5'h13;
            18: srcPos = 5'h14;
            19: srcPos = 5'h12;
            20: srcPos = 5'h17;
            21: srcPos = 5'h18;
            22: srcPos = 5'h19;
            23: srcPos = 5'h1A;
            24: srcPos = 5'h1B;
            default: srcPos = 5'h00;
        endcase
    endfunction : srcPos

    function automatic logic [15:0] srcVector(input int idx);
        case (idx)
            0: srcVector = 16'h0004;
            1: srcVector = 16'h0006;
            2: srcVector = 16'h0008;
            3: srcVector = 16'h000A;
            4: srcVector = 16'h000C;
            5: srcVector = 16'h0012;
            6: srcVector = 16'h0014;
            7: srcVector = 16'h0016;
            8: srcVector = 16'h0018;
            9: srcVector = 16'h001A;
            10: srcVector = 16'h001C;
            11: srcVector = 16'h001E;
            12: srcVector = 16'h0020;
            13: srcVector = 16'h0022;
            14: srcVector = 16'h0024;
            15: srcVector = 16'h0026;
            16: srcVector = 16'h0028;
            17: srcVector = 16'h002A;
            18: srcVector = 16'h002C;
            19: srcVector = 16'h002E;
            20: srcVector = 16'h0032;
            21: srcVector = 16'h0034;
            22: srcVector = 16'h0036;
            23: srcVector = 16'h0038;
            24: srcVector = 16'h003A;
            default: srcVector = 16'h0004;
        endcase
    endfunction : srcVector

    function automatic logic [15:0] byteWrite(
        input logic [15:0] old,
        input logic [31:0] data,
        input logic [3:0] strb
    );
        logic [15:0] res;
        res = old;
        if (strb[0])
        begin
            res[7:0] = data[7:0];
        end
        if (strb[1])
        begin
            res[15:8] = data[15:8];
        end
        byteWrite = res;
    endfunction : byteWrite

    // ****************************************
    // state
    // ****************************************
    vip_pkg::vip_state_t state_reg;
    vip_pkg::vip_state_t state_next;

    logic [31:0] implMask;
    logic [31:0] hwSet;
    logic [31:0] pending;
    logic [31:0] allPrio;
    logic hiFound;
    logic loFound;
    logic [4:0] hiPos;
    logic [4:0] loPos;
    logic [15:0] hiVec;
    logic [15:0] loVec;
    logic takeHigh;
    logic takeLow;
    logic [31:0] ackClear;
    logic [31:0] flagsNow;
    logic lvIrq;

    // adc flag is absent without the converter
    assign implMask = HAS_ADC
        ? {`VIP_IMPL_1, `VIP_IMPL_0}
        : ({`VIP_IMPL_1, `VIP_IMPL_0} & ~(32'h1 << `VIP_ADC_BIT));

    assign lvIrq = lowVoltageEvent && !state_reg.lowVoltageMode;

    // hardware request sources onto flag positions
    always_comb
    begin
        hwSet = 32'h0000_0000;
        hwSet[0] = lvIrq;
        hwSet[4:1] = pinEdgeIrq;
        hwSet[7] = periphIrq.serial6RxErr;
        hwSet[8] = periphIrq.serial6RxEnd;
        hwSet[9] = periphIrq.serial6TxEnd;
        hwSet[10] = periphIrq.clockedSerialEnd | periphIrq.serial0TxEnd;
        hwSet[11] = periphIrq.timerH1;
        hwSet[12] = periphIrq.timerH0;
        hwSet[13] = periphIrq.timer50;
        hwSet[14] = periphIrq.timer000;
        hwSet[15] = periphIrq.timer010;
        hwSet[16] = periphIrq.adcEnd;
        hwSet[17] = periphIrq.serial0Rx;
        hwSet[18] = periphIrq.rtcInterval;
        hwSet[19] = periphIrq.timer51;
        hwSet[20] = periphIrq.keyReturn;
        hwSet[21] = periphIrq.rtcFixed;
        hwSet[23] = periphIrq.timer52;
        hwSet[24] = periphIrq.timerH2;
        hwSet[25] = periphIrq.manchesterRxEnd;
        hwSet[26] = periphIrq.remoteEdge;
        hwSet[27] = periphIrq.remoteError | periphIrq.remoteGuidePulse
            | periphIrq.remoteDataDone | periphIrq.remoteShiftFull;
        hwSet = hwSet & implMask;
    end

    // ****************************************
    // arbitration
    // ****************************************
    always_comb
    begin
        flagsNow = {state_reg.req1, state_reg.req0};
        allPrio = {state_reg.prio1, state_reg.prio0};
        // one mask bit gates shared sources alike
        pending = flagsNow & ~{state_reg.mask1, state_reg.mask0} & implMask;
        hiFound = 1'b0;
        loFound = 1'b0;
        hiPos = 5'h00;
        loPos = 5'h00;
        hiVec = 16'h0000;
        loVec = 16'h0000;
        // walk backwards so the lowest index is kept
        for (int i = `VIP_LAST_SRC; i >= 0; i--)
        begin
            if (pending[srcPos(i)] && !allPrio[srcPos(i)])
            begin
                hiFound = 1'b1;
                hiPos = srcPos(i);
                hiVec = srcVector(i);
            end
            if (pending[srcPos(i)] && allPrio[srcPos(i)])
            begin
                loFound = 1'b1;
                loPos = srcPos(i);
                loVec = srcVector(i);
            end
        end
    end

    // a low handler leaves inService set, so high still gets in
    assign takeHigh = instrBoundary && !state_reg.ack.valid && !state_reg.breakPending
        && state_reg.globalEnable && hiFound;
    assign takeLow = instrBoundary && !state_reg.ack.valid && !state_reg.breakPending
        && state_reg.globalEnable && state_reg.inService && !hiFound && loFound;
    assign ackClear = takeHigh ? (32'h1 << hiPos) : (takeLow ? (32'h1 << loPos) : 32'h0);

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        logic [31:0] flagsNew;
        logic [7:0] wa;
        logic wrHit;
        logic rdHit;
        logic [31:0] rd;
        flagsNew = 32'h0;
        wa = 8'h00;
        wrHit = 1'b0;
        rdHit = 1'b0;
        rd = 32'h0;
        state_next = state_reg;
        state_next.ack.valid = 1'b0;

        // reset pin crosses in through two flops
        state_next.pinMeta = resetPinN;
        state_next.pinSync = state_reg.pinMeta;
        state_next.resetCause = {watchdogOverflow,
            lowVoltageEvent && state_reg.lowVoltageMode, powerOnClear,
            !state_reg.pinSync};
        state_next.resetReq = |state_next.resetCause;

        // ---- bus write ----
        if (s_axi_awvalid && s_axi_awready)
        begin
            state_next.awHeld = 1'b1;
            state_next.awAddr = s_axi_awaddr[7:0];
            state_next.awOut = |s_axi_awaddr[31:8];
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            state_next.wHeld = 1'b1;
            state_next.wData = s_axi_wdata;
            state_next.wStrb = s_axi_wstrb;
        end
        flagsNew = {state_reg.req1, state_reg.req0};
        case (state_reg.wrState)
            vip_pkg::VIP_BUS_IDLE:
            begin
                if (state_reg.awHeld && state_reg.wHeld)
                begin
                    wa = state_reg.awAddr;
                    wrHit = !state_reg.awOut;
                    case (wa)
                        `VIP_OFF_REQ0: flagsNew[15:0] = byteWrite(state_reg.req0,
                            state_reg.wData, state_reg.wStrb);
                        `VIP_OFF_REQ1: flagsNew[31:16] = byteWrite(state_reg.req1,
                            state_reg.wData, state_reg.wStrb);
                        `VIP_OFF_MASK0: state_next.mask0 = byteWrite(state_reg.mask0,
                            state_reg.wData, state_reg.wStrb);
                        `VIP_OFF_MASK1: state_next.mask1 = byteWrite(state_reg.mask1,
                            state_reg.wData, state_reg.wStrb);
                        `VIP_OFF_PRIO0: state_next.prio0 = byteWrite(state_reg.prio0,
                            state_reg.wData, state_reg.wStrb);
                        `VIP_OFF_PRIO1: state_next.prio1 = byteWrite(state_reg.prio1,
                            state_reg.wData, state_reg.wStrb);
                        `VIP_OFF_CTRL:
                        begin
                            if (state_reg.wStrb[0])
                            begin
                                state_next.globalEnable = state_reg.wData[`VIP_CTRL_IE];
                                state_next.inService = state_reg.wData[`VIP_CTRL_ISP];
                                state_next.lowVoltageMode = state_reg.wData[`VIP_CTRL_LVMODE];
                            end
                        end
                        `VIP_OFF_STATUS: wrHit = wrHit;
                        default: wrHit = 1'b0;
                    endcase
                    state_next.awHeld = 1'b0;
                    state_next.wHeld = 1'b0;
                    state_next.bresp = wrHit ? `VIP_RESP_OKAY : `VIP_RESP_SLVERR;
                    state_next.wrState = vip_pkg::VIP_BUS_RESP;
                end
            end
            vip_pkg::VIP_BUS_RESP:
            begin
                if (s_axi_bready)
                begin
                    state_next.wrState = vip_pkg::VIP_BUS_IDLE;
                end
            end
            default: state_next.wrState = vip_pkg::VIP_BUS_IDLE;
        endcase

        // core restores its status word on handler return
        if (pswRestore)
        begin
            state_next.globalEnable = pswRestoreIe;
            state_next.inService = pswRestoreIsp;
        end

        // ack clears its flag; a fresh event in that cycle wins
        flagsNew = ((flagsNew & ~ackClear) | hwSet) & implMask;
        state_next.req0 = flagsNew[15:0];
        state_next.req1 = flagsNew[31:16];

        // ---- acknowledge ----
        if (instrBoundary && !state_reg.ack.valid && state_reg.breakPending)
        begin
            state_next.breakPending = 1'b0;
            state_next.ack.valid = 1'b1;
            state_next.ack.software = 1'b1;
            state_next.ack.vector = `VIP_VEC_BREAK;
            state_next.ack.savedIe = state_reg.globalEnable;
            state_next.ack.savedIsp = state_reg.inService;
            state_next.globalEnable = 1'b0;
        end
        else if (takeHigh || takeLow)
        begin
            state_next.ack.valid = 1'b1;
            state_next.ack.software = 1'b0;
            state_next.ack.vector = takeHigh ? hiVec : loVec;
            state_next.ack.savedIe = state_reg.globalEnable;
            state_next.ack.savedIsp = state_reg.inService;
            state_next.globalEnable = 1'b0;
            // only a high-group handler shuts out the low group
            state_next.inService = takeLow;
        end

        // break waits for a boundary; a new one wins over the clear
        if (breakInstruction)
        begin
            state_next.breakPending = 1'b1;
        end

        // wake on any unmasked flag, enable or not
        state_next.wakeup = |pending;

        // ---- bus read ----
        case (state_reg.rdState)
            vip_pkg::VIP_BUS_IDLE:
            begin
                if (s_axi_arvalid)
                begin
                    rdHit = !(|s_axi_araddr[31:8]);
                    case (s_axi_araddr[7:0])
                        `VIP_OFF_REQ0: rd = {16'h0000, state_reg.req0};
                        `VIP_OFF_REQ1: rd = {16'h0000, state_reg.req1};
                        `VIP_OFF_MASK0: rd = {16'h0000, state_reg.mask0};
                        `VIP_OFF_MASK1: rd = {16'h0000, state_reg.mask1};
                        `VIP_OFF_PRIO0: rd = {16'h0000, state_reg.prio0};
                        `VIP_OFF_PRIO1: rd = {16'h0000, state_reg.prio1};
                        `VIP_OFF_CTRL: rd = {29'h0000_0000, state_reg.lowVoltageMode,
                            state_reg.inService, state_reg.globalEnable};
                        `VIP_OFF_STATUS: rd = {state_reg.ack.vector, 12'h000,
                            state_reg.breakPending, loFound, hiFound, state_reg.wakeup};
                        default: rdHit = 1'b0;
                    endcase
                    if (!rdHit)
                    begin
                        rd = 32'h0000_0000;
                    end
                    state_next.rdata = rd;
                    state_next.rresp = rdHit ? `VIP_RESP_OKAY : `VIP_RESP_SLVERR;
                    state_next.rdState = vip_pkg::VIP_BUS_RESP;
                end
            end
            vip_pkg::VIP_BUS_RESP:
            begin
                if (s_axi_rready)
                begin
                    state_next.rdState = vip_pkg::VIP_BUS_IDLE;
                end
            end
            default: state_next.rdState = vip_pkg::VIP_BUS_IDLE;
        endcase
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_reg <= '0;
            state_reg.req0 <= `VIP_REQ_RESET;
            state_reg.req1 <= `VIP_REQ_RESET;
            state_reg.mask0 <= `VIP_MASK_RESET;
            state_reg.mask1 <= `VIP_MASK_RESET;
            state_reg.prio0 <= `VIP_PRIO_RESET;
            state_reg.prio1 <= `VIP_PRIO_RESET;
            state_reg.inService <= 1'b1;
            state_reg.pinMeta <= 1'b1;
            state_reg.pinSync <= 1'b1;
            state_reg.wrState <= vip_pkg::VIP_BUS_IDLE;
            state_reg.rdState <= vip_pkg::VIP_BUS_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign s_axi_awready = !state_reg.awHeld && (state_reg.wrState == vip_pkg::VIP_BUS_IDLE);
    assign s_axi_wready = !state_reg.wHeld && (state_reg.wrState == vip_pkg::VIP_BUS_IDLE);
    assign s_axi_bvalid = (state_reg.wrState == vip_pkg::VIP_BUS_RESP);
    assign s_axi_bresp = state_reg.bresp;
    assign s_axi_arready = (state_reg.rdState == vip_pkg::VIP_BUS_IDLE);
    assign s_axi_rvalid = (state_reg.rdState == vip_pkg::VIP_BUS_RESP);
    assign s_axi_rdata = state_reg.rdata;
    assign s_axi_rresp = state_reg.rresp;
    assign ack = state_reg.ack;
    assign standbyRelease = state_reg.wakeup;
    assign resetRequest = state_reg.resetReq;
    assign resetCause = state_reg.resetCause;
    assign resetVector = `VIP_VEC_RESET;

endmodule : vip_ctrl

`default_nettype wire

// File: tb/vip_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "vip_cfg.svh"
module vip_chk (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic instrBoundary,
    input wire logic breakInstruction,
    input wire logic watchdogOverflow,
    input wire logic s_axi_awready,
    input wire logic s_axi_arready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_rvalid,
    input wire vip_pkg::vip_ack_t ack,
    input wire logic resetRequest
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_ack_single: assert property (ack.valid |=> !ack.valid) else $error("ack long");
    a_ack_boundary: assert property (ack.valid |-> $past(instrBoundary))
        else $error("ack off boundary");
    a_break_first: assert property (breakInstruction ##1 (instrBoundary && !ack.valid)
        |=> ack.valid && ack.software) else $error("break late");
    a_break_vector: assert property (ack.valid && ack.software
        |-> ack.vector == `VIP_VEC_BREAK) else $error("break vector");
    a_maskable_ie: assert property (ack.valid && !ack.software |-> ack.savedIe)
        else $error("ack with ie off");
    a_wdt_reset: assert property (watchdogOverflow |=> resetRequest)
        else $error("no reset request");
    a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("aw open");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar open");
    cover property (ack.valid && ack.software);
    cover property (ack.valid && !ack.software);
    cover property (resetRequest);
endmodule : vip_chk
bind vip_ctrl vip_chk u_chk (.sys_clk, .rst, .instrBoundary, .breakInstruction,
    .watchdogOverflow, .s_axi_awready, .s_axi_arready, .s_axi_bvalid, .s_axi_rvalid, .ack,
    .resetRequest);
`default_nettype wire

// File: tb/vip_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module vip_core_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire vip_pkg::vip_ack_t ack,
    output logic instrBoundary,
    output logic pswRestore,
    output logic pswRestoreIe,
    output logic pswRestoreIsp
);
    // handler runs four cycles, first one mid-instruction, then returns
    logic [2:0] handlerCnt = 3'h0;
    assign instrBoundary = (handlerCnt != 3'h4);
    always_ff @(posedge sys_clk)
    begin
        pswRestore <= 1'b0;
        if (rst)
        begin
            handlerCnt <= 3'h0;
            pswRestoreIe <= 1'b0;
            pswRestoreIsp <= 1'b1;
        end
        else if (ack.valid)
        begin
            handlerCnt <= 3'h4;
            pswRestoreIe <= ack.savedIe;
            pswRestoreIsp <= ack.savedIsp;
        end
        else if (handlerCnt != 3'h0)
        begin
            handlerCnt <= handlerCnt - 3'h1;
            pswRestore <= (handlerCnt == 3'h1);
        end
    end
endmodule : vip_core_model
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "vip_cfg.svh"
`define C(n, e, a) total_checks++; \
    if ((a) !== (e)) begin mismatches++; $display("[FAIL] %s exp %h got %h", n, e, a); end
module tb_top;
    logic sys_clk = 1'b0, rst = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, resetPinN = 1'b1;
    logic powerOnClear = 1'b0, lowVoltageEvent = 1'b0, breakInstruction = 1'b0;
    logic watchdogOverflow = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF, pinEdgeIrq = 4'h0, resetCause;
    logic [1:0] s_axi_bresp, s_axi_rresp, lastResp;
    logic s_axi_rvalid, instrBoundary, pswRestore, pswRestoreIe, pswRestoreIsp;
    logic standbyRelease, resetRequest;
    logic [15:0] resetVector;
    vip_pkg::vip_periph_t periphIrq = '0;
    vip_pkg::vip_ack_t ack;
    int mismatches = 0, total_checks = 0, cycles = 0;
    vip_ctrl u_dut (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .lowVoltageEvent, .pinEdgeIrq, .periphIrq, .instrBoundary,
        .breakInstruction, .pswRestore, .pswRestoreIe, .pswRestoreIsp, .resetPinN,
        .powerOnClear, .watchdogOverflow, .ack, .standbyRelease, .resetRequest, .resetCause,
        .resetVector);
    vip_core_model u_core (.sys_clk, .rst, .ack, .instrBoundary, .pswRestore, .pswRestoreIe,
        .pswRestoreIsp);
    always #25 sys_clk = ~sys_clk;
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        {s_axi_awaddr, s_axi_wdata} <= {24'h0, a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do
        begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        s_axi_araddr <= {24'h0, a};
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do
        begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        lastResp = s_axi_rresp;
        `C("read", e, s_axi_rdata)
    endtask : rd
    // one-cycle pulse on {watchdog, low voltage, break, pins, peripherals}
    task automatic pu(input logic [30:0] v);
        @(posedge sys_clk);
        {watchdogOverflow, lowVoltageEvent, breakInstruction, pinEdgeIrq, periphIrq} <= v;
        @(posedge sys_clk);
        {watchdogOverflow, lowVoltageEvent, breakInstruction, pinEdgeIrq, periphIrq} <= '0;
    endtask : pu
    task automatic wa(input logic [15:0] v, input logic sw);
        for (int n = 0; n < 60 && ack.valid !== 1'b1; n++) @(posedge sys_clk);
        `C("ack", 1'b1, ack.valid)
        `C("vector", v, ack.vector)
        `C("software", sw, ack.software)
        @(posedge sys_clk);
    endtask : wa
    task automatic t_rst;
        rd(`VIP_OFF_REQ0, 32'h0);
        rd(`VIP_OFF_REQ1, 32'h0);
        for (int a = 8; a < 24; a += 4) rd(8'(a), 32'hFFFF);
        rd(8'h20, 32'h0);
        `C("resp", `VIP_RESP_SLVERR, lastResp)
        $display("t_rst done");
    endtask : t_rst
    task automatic t_order;
        wr(`VIP_OFF_MASK0, 32'h0);
        wr(`VIP_OFF_CTRL, 32'h3);
        pu(31'h0F00_0000);
        for (int i = 0; i < 4; i++) wa(16'h0006 + 16'(2 * i), 1'b0);
        rd(`VIP_OFF_REQ0, 32'h0);
        wr(`VIP_OFF_PRIO0, 32'hFFEF);
        pu(31'h0900_0000);
        wa(16'h000C, 1'b0);
        wa(16'h0006, 1'b0);
        $display("t_order done");
    endtask : t_order
    task automatic t_mask;
        // let the last handler return first
        repeat (8) @(posedge sys_clk);
        wr(`VIP_OFF_MASK0, 32'hFFFF);
        pu(31'h0100_0000);
        rd(`VIP_OFF_REQ0, 32'h2);
        `C("wake", 1'b0, standbyRelease)
        wr(`VIP_OFF_REQ0, 32'h0);
        rd(`VIP_OFF_REQ0, 32'h0);
        wr(`VIP_OFF_CTRL, 32'h2);
        wr(`VIP_OFF_MASK0, 32'hFFFD);
        wr(`VIP_OFF_REQ0, 32'h2);
        @(posedge sys_clk);
        `C("wake", 1'b1, standbyRelease)
        wr(`VIP_OFF_CTRL, 32'h3);
        wa(16'h0006, 1'b0);
        $display("t_mask done");
    endtask : t_mask
    task automatic t_src;
        int pos[12] = '{23, 22, 21, 20, 19, 5, 4, 3, 2, 1, 0, 29};
        logic [15:0] vec[12] = '{16'h0012, 16'h0014, 16'h0016, 16'h0018, 16'h0018, 16'h0036,
            16'h0038, 16'h003A, 16'h003A, 16'h003A, 16'h003A, 16'h0004};
        wr(`VIP_OFF_MASK0, 32'h0);
        wr(`VIP_OFF_MASK1, 32'h0);
        for (int i = 0; i < 12; i++)
        begin
            pu(31'h1 << pos[i]);
            wa(vec[i], 1'b0);
        end
        $display("t_src done");
    endtask : t_src
    task automatic t_brk;
        // its restore would overwrite the enable
        repeat (8) @(posedge sys_clk);
        wr(`VIP_OFF_CTRL, 32'h2);
        pu(31'h1100_0000);
        wa(`VIP_VEC_BREAK, 1'b1);
        repeat (8) @(posedge sys_clk);
        wr(`VIP_OFF_CTRL, 32'h3);
        wa(16'h0006, 1'b0);
        pu(31'h4000_0000);
        @(posedge sys_clk);
        `C("rstreq", 5'h18, {resetRequest, resetCause})
        `C("rstvec", `VIP_VEC_RESET, resetVector)
        $display("t_brk done");
    endtask : t_brk
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : complete_run
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            complete_run();
        end
    end
    initial
    begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        t_rst();
        t_order();
        t_mask();
        t_src();
        t_brk();
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
